// ---- src/sfcs_defs.svh ----
`ifndef SFCS_DEFS_SVH
`define SFCS_DEFS_SVH
// Register byte offsets
`define SFCS_OFS_RX_CFG 12'h000
`define SFCS_OFS_TX_CFG 12'h004
`define SFCS_OFS_RX_STAT 12'h008
`define SFCS_OFS_SETUP 12'h00C
`define SFCS_OFS_IRQ_STAT 12'h010
`define SFCS_OFS_IRQ_MASK 12'h014
`define SFCS_OFS_TX_STAT 12'h018
// Field positions
`define SFCS_BIT_CLEAR 7
`define SFCS_BIT_COND 6
`define SFCS_BIT_OVR 7
`define SFCS_BIT_ENABLE 0
`define SFCS_BIT_FDPX 1
// Reset values and sizes
`define SFCS_RST_2B 2'h0
`define SFCS_RST_8B 8'h00
`define SFCS_LVL_W 3
`define SFCS_DEPTH 4
`define SFCS_HALF_DEPTH 2
`endif

// ---- src/sfcs_pkg.sv ----
package sfcs_pkg;
  typedef struct packed {
    logic [1:0] thr;
    logic cond;
  } sfcs_cfg_s;
  typedef struct packed {
    logic push;
    logic pop;
    logic [7:0] data;
  } sfcs_strm_s;
  typedef enum logic [2:0] {
    SFCS_IDLE = 3'b001,
    SFCS_SETUP = 3'b010,
    SFCS_ACCESS = 3'b100
  } sfcs_apb_e;
endpackage

// ---- src/sfcs_queue.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sfcs_defs.svh"
// Small byte queue with registered read data and a fill level
module sfcs_queue (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clr,
  input wire logic [2:0] cap,
  // Stream
  input wire logic push,
  input wire logic [7:0] wdata,
  input wire logic pop,
  output logic [7:0] rdata_ff,
  output logic [2:0] level_ff,
  output logic full
);
  logic [7:0] mem_ff [0:3];
  logic [1:0] wp_ff;
  logic [1:0] rp_ff;
  logic do_push;
  logic do_pop;

  assign full = (level_ff >= cap);
  assign do_push = push && !full;
  assign do_pop = pop && (level_ff != 3'h0);

  // Storage
  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem_ff[wp_ff] <= wdata;
    end
  end

  // Pointers and level; clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_ff <= 2'h0;
      rp_ff <= 2'h0;
      level_ff <= 3'h0;
      rdata_ff <= 8'h00;
    end else if (clr) begin
      wp_ff <= 2'h0;
      rp_ff <= 2'h0;
      level_ff <= 3'h0;
    end else begin
      if (do_push) begin
        wp_ff <= (cap == 3'h2) ? {1'b0, ~wp_ff[0]} : wp_ff + 2'h1;
      end
      if (do_pop) begin
        rdata_ff <= mem_ff[rp_ff];
        rp_ff <= (cap == 3'h2) ? {1'b0, ~rp_ff[0]} : rp_ff + 2'h1;
      end
      level_ff <= level_ff + {2'h0, do_push} - {2'h0, do_pop};
    end
  end
endmodule
`default_nettype wire

// ---- src/sfcs_top.sv ----
// Operation
// - Writing 1 to the receive clear bit empties the receive queue, zeroes its level and resets its read pointer.
// - Receive interrupt fires on reaching threshold, and with condition bit 1 also when a read leaves more than threshold.
// - Receive threshold code maps to 4,1,2,3 bytes in half duplex and 2,1,2,1 in full duplex.
// - Writing 1 to the transmit clear bit empties the transmit queue, zeroes its level and resets its write pointer.
// - Transmit interrupt fires on reaching threshold, and with condition bit 1 also when a take leaves it below threshold.
// - Transmit threshold code maps to 0,1,2,3 bytes outside full duplex and 0,1,0,1 in full duplex.
// - Receive status bit 7 is a read-only overrun flag.
// - Receive status bits 2-0 report receive occupancy, 0 to 4 bytes.
// - Unused bits read 0 and all implemented fields reset to 0.
// - Enabled queues are 4 bytes in half duplex and 2 bytes each in full duplex.
`timescale 1ns/1ns
`default_nettype none
`include "sfcs_defs.svh"
module sfcs_top (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  // Channel side: receive shift register pushes, transmit shift register pops
  input wire sfcs_pkg::sfcs_strm_s rx_in,
  input wire sfcs_pkg::sfcs_strm_s tx_in,
  output logic [7:0] rx_data_ff,
  output logic [7:0] tx_data_ff,
  output logic rx_irq_ff,
  output logic tx_irq_ff,
  output logic irq_ff
);
  import sfcs_pkg::*;

  sfcs_cfg_s rx_cfg_ff;
  sfcs_cfg_s tx_cfg_ff;
  logic queue_en_ff;
  logic full_duplex_ff;
  logic rx_ovr_ff;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_mask_ff;
  logic rx_clr;
  logic tx_clr;
  logic [2:0] rx_lvl;
  logic [2:0] tx_lvl;
  logic [2:0] rx_cap;
  logic [2:0] tx_cap;
  logic [2:0] rx_thr;
  logic [2:0] tx_thr;
  logic rx_full;
  logic tx_full;
  logic [7:0] rx_q_data;
  logic [7:0] tx_q_data;
  logic acc;
  logic wr;
  logic rd;
  logic rx_ev;
  logic tx_ev;
  logic [31:0] nxt_prdata;
  logic nxt_err;

  // Two-cycle access phase; slave answers ready on its second cycle
  assign acc = psel && penable && !pready_ff;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign rx_clr = wr && paddr == `SFCS_OFS_RX_CFG && pwdata[`SFCS_BIT_CLEAR];
  assign tx_clr = wr && paddr == `SFCS_OFS_TX_CFG && pwdata[`SFCS_BIT_CLEAR];

  // Queue size from duplex mode; disabled queues hold nothing
  always_comb begin
    rx_cap = 3'h0;
    tx_cap = 3'h0;
    if (queue_en_ff) begin
      rx_cap = full_duplex_ff ? 3'd`SFCS_HALF_DEPTH : 3'd`SFCS_DEPTH;
      tx_cap = full_duplex_ff ? 3'd`SFCS_HALF_DEPTH : 3'd`SFCS_DEPTH;
    end
  end

  // Threshold decode tables
  always_comb begin
    case (rx_cfg_ff.thr)
      2'b00: rx_thr = full_duplex_ff ? 3'd2 : 3'd4;
      2'b01: rx_thr = 3'd1;
      2'b10: rx_thr = 3'd2;
      2'b11: rx_thr = full_duplex_ff ? 3'd1 : 3'd3;
      default: rx_thr = 3'd0;
    endcase
    case (tx_cfg_ff.thr)
      2'b00: tx_thr = 3'd0;
      2'b01: tx_thr = 3'd1;
      2'b10: tx_thr = full_duplex_ff ? 3'd0 : 3'd2;
      2'b11: tx_thr = full_duplex_ff ? 3'd1 : 3'd3;
      default: tx_thr = 3'd0;
    endcase
  end

  sfcs_queue u_rxq (
    .pclk(pclk),
    .presetn(presetn),
    .clr(rx_clr),
    .cap(rx_cap),
    .push(rx_in.push),
    .wdata(rx_in.data),
    .pop(rx_in.pop),
    .rdata_ff(rx_q_data),
    .level_ff(rx_lvl),
    .full(rx_full)
  );

  sfcs_queue u_txq (
    .pclk(pclk),
    .presetn(presetn),
    .clr(tx_clr),
    .cap(tx_cap),
    .push(tx_in.push),
    .wdata(tx_in.data),
    .pop(tx_in.pop),
    .rdata_ff(tx_q_data),
    .level_ff(tx_lvl),
    .full(tx_full)
  );

  // Interrupt events, judged on the level after the current push or pop
  always_comb begin
    rx_ev = 1'b0;
    tx_ev = 1'b0;
    if (queue_en_ff && !rx_clr) begin
      if (rx_in.push && !rx_full && rx_lvl + 3'h1 == rx_thr) begin
        rx_ev = 1'b1;
      end
      if (rx_cfg_ff.cond && rx_in.pop && rx_lvl != 3'h0 && rx_lvl - 3'h1 > rx_thr) begin
        rx_ev = 1'b1;
      end
    end
    if (queue_en_ff && !tx_clr && tx_in.pop && tx_lvl != 3'h0) begin
      if (tx_lvl - 3'h1 == tx_thr) begin
        tx_ev = 1'b1;
      end
      if (tx_cfg_ff.cond && tx_lvl - 3'h1 < tx_thr) begin
        tx_ev = 1'b1;
      end
    end
  end

  // Configuration registers; clear bits never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cfg_ff <= '0;
      tx_cfg_ff <= '0;
      queue_en_ff <= 1'b0;
      full_duplex_ff <= 1'b0;
      irq_mask_ff <= `SFCS_RST_2B;
    end else if (wr) begin
      case (paddr)
        `SFCS_OFS_RX_CFG: rx_cfg_ff <= '{thr: pwdata[1:0], cond: pwdata[`SFCS_BIT_COND]};
        `SFCS_OFS_TX_CFG: tx_cfg_ff <= '{thr: pwdata[1:0], cond: pwdata[`SFCS_BIT_COND]};
        `SFCS_OFS_SETUP: begin
          queue_en_ff <= pwdata[`SFCS_BIT_ENABLE];
          full_duplex_ff <= pwdata[`SFCS_BIT_FDPX];
        end
        `SFCS_OFS_IRQ_MASK: irq_mask_ff <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Overrun: sticky until receive clear; the clear beats a same-cycle overrun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ovr_ff <= 1'b0;
    end else if (rx_in.push && rx_full && !rx_clr) begin
      rx_ovr_ff <= 1'b1;
    end else if (rx_clr) begin
      rx_ovr_ff <= 1'b0;
    end
  end

  // Sticky status; a read clears it but a same-cycle event survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= `SFCS_RST_2B;
    end else begin
      irq_stat_ff <= ((rd && paddr == `SFCS_OFS_IRQ_STAT) ? 2'b00 : irq_stat_ff)
                     | {tx_ev, rx_ev};
    end
  end

  // Registered interrupt and data outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_irq_ff <= 1'b0;
      tx_irq_ff <= 1'b0;
      irq_ff <= 1'b0;
      rx_data_ff <= `SFCS_RST_8B;
      tx_data_ff <= `SFCS_RST_8B;
    end else begin
      rx_irq_ff <= rx_ev;
      tx_irq_ff <= tx_ev;
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
      rx_data_ff <= rx_q_data;
      tx_data_ff <= tx_q_data;
    end
  end

  // Read mux; unmapped offsets answer with an error
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    nxt_err = 1'b0;
    case (paddr)
      `SFCS_OFS_RX_CFG: nxt_prdata = {24'h00_0000, 1'b0, rx_cfg_ff.cond, 4'h0, rx_cfg_ff.thr};
      `SFCS_OFS_TX_CFG: nxt_prdata = {24'h00_0000, 1'b0, tx_cfg_ff.cond, 4'h0, tx_cfg_ff.thr};
      `SFCS_OFS_RX_STAT: nxt_prdata = {24'h00_0000, rx_ovr_ff, 4'h0, rx_lvl};
      `SFCS_OFS_SETUP: nxt_prdata = {30'h0000_0000, full_duplex_ff, queue_en_ff};
      `SFCS_OFS_IRQ_STAT: nxt_prdata = {30'h0000_0000, irq_stat_ff};
      `SFCS_OFS_IRQ_MASK: nxt_prdata = {30'h0000_0000, irq_mask_ff};
      `SFCS_OFS_TX_STAT: nxt_prdata = {29'h0000_0000, tx_lvl};
      default: nxt_err = 1'b1;
    endcase
  end

  // Bus answer: pready one cycle after access starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc && nxt_err;
      if (rd) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  // Clearing empties the queue on the next edge
  a_rx_clear_lvl: assert property (@(posedge pclk) disable iff (!presetn)
    rx_clr |=> rx_lvl == 3'h0) else $error("rx level not zero after clear");
  a_tx_clear_lvl: assert property (@(posedge pclk) disable iff (!presetn)
    tx_clr |=> tx_lvl == 3'h0) else $error("tx level not zero after clear");
  a_rx_irq_reach: assert property (@(posedge pclk) disable iff (!presetn)
    (queue_en_ff && !rx_clr && rx_in.push && !rx_in.pop && !rx_full && rx_lvl + 3'h1 == rx_thr)
    |=> rx_irq_ff) else $error("rx irq missed at threshold");
  a_tx_irq_reach: assert property (@(posedge pclk) disable iff (!presetn)
    (queue_en_ff && !tx_clr && tx_in.pop && tx_lvl != 3'h0 && tx_lvl - 3'h1 == tx_thr)
    |=> tx_irq_ff) else $error("tx irq missed at threshold");
  a_rx_thr_half: assert property (@(posedge pclk) disable iff (!presetn)
    (!full_duplex_ff && rx_cfg_ff.thr == 2'b00) |-> rx_thr == 3'd4)
    else $error("rx threshold decode");
  a_tx_thr_full: assert property (@(posedge pclk) disable iff (!presetn)
    (full_duplex_ff && tx_cfg_ff.thr == 2'b10) |-> tx_thr == 3'd0)
    else $error("tx threshold decode");
  a_ovr_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_in.push && rx_full && !rx_clr) |=> rx_ovr_ff) else $error("overrun not set");
  a_lvl_bound: assert property (@(posedge pclk) disable iff (!presetn)
    rx_lvl <= 3'd4 && tx_lvl <= 3'd4) else $error("level above four");
  a_size_fdpx: assert property (@(posedge pclk) disable iff (!presetn)
    (queue_en_ff && full_duplex_ff) |-> rx_cap == 3'd2) else $error("queue size");
  a_stat_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && paddr == `SFCS_OFS_RX_STAT) |=> prdata_ff == {24'h00_0000, $past(rx_ovr_ff), 4'h0,
    $past(rx_lvl)}) else $error("rx status read");
endmodule
`default_nettype wire

// ---- dv/sfcs_chan_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Channel stand-in: shift registers on one side, software byte port on the other
module sfcs_chan_model (
  // Clock
  input wire logic pclk,
  // Queue strobes
  output var sfcs_pkg::sfcs_strm_s rx_out,
  output var sfcs_pkg::sfcs_strm_s tx_out
);
  import sfcs_pkg::*;
  // Quiet lines at start
  initial begin
    rx_out = '0;
    tx_out = '0;
  end
  // One-cycle push or pop; idle data flips so a stale byte never looks valid
  task automatic strobe(input logic is_tx, input logic psh, input logic [7:0] d);
    sfcs_strm_s s;
    s = '{psh, !psh, d};
    @(posedge pclk);
    if (is_tx) tx_out <= s;
    else rx_out <= s;
    @(posedge pclk);
    if (is_tx) tx_out <= '{1'b0, 1'b0, ~d};
    else rx_out <= '{1'b0, 1'b0, ~d};
  endtask
endmodule
`default_nettype wire

// ---- dv/test_serial_fifo_config_status.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sfcs_defs.svh"
module test_serial_fifo_config_status;
  import sfcs_pkg::*;
  localparam logic [11:0] A_RC = `SFCS_OFS_RX_CFG;
  localparam logic [11:0] A_TC = `SFCS_OFS_TX_CFG;
  localparam logic [11:0] A_RS = `SFCS_OFS_RX_STAT;
  localparam logic [11:0] A_IS = `SFCS_OFS_IRQ_STAT;
  logic pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff;
  logic rx_irq_ff, tx_irq_ff, irq_ff, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_ff;
  logic [7:0] rx_data_ff, tx_data_ff;
  sfcs_strm_s rx_in, tx_in;
  int miscompares, num_checks, cap, th;
  int rxh[4] = '{4, 1, 2, 3};
  int rxf[4] = '{2, 1, 2, 1};
  int txh[4] = '{0, 1, 2, 3};
  int txf[4] = '{0, 1, 0, 1};
  int rx_pulses = 0;
  int tx_pulses = 0;
  int exp_rx = 0;
  int exp_tx = 0;
  // Design and channel stand-in
  sfcs_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
    .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .rx_in(rx_in), .tx_in(tx_in),
    .rx_data_ff(rx_data_ff), .tx_data_ff(tx_data_ff), .rx_irq_ff(rx_irq_ff),
    .tx_irq_ff(tx_irq_ff), .irq_ff(irq_ff));
  sfcs_chan_model u_chan (.pclk(pclk), .rx_out(rx_in), .tx_out(tx_in));
  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Count one-cycle event pulses; a lost or doubled pulse shows in the totals
  always @(posedge pclk) begin
    if (rx_irq_ff === 1'b1) rx_pulses <= rx_pulses + 1;
    if (tx_irq_ff === 1'b1) tx_pulses <= tx_pulses + 1;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready_ff !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n == 50) miscompares++;
    if (!wr) chk(prdata_ff, exp);
    last_err = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0, exp);
  endtask
  // Let pops, status and the interrupt level land
  task automatic settle;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
  endtask
  // Hang guard, far beyond the roughly one thousand cycles the run needs
  initial begin
    #100000;
    miscompares++;
    give_verdict;
  end
  initial begin
    {psel, penable, pwrite, presetn} = '0;
    paddr = '0;
    pwdata = '0;
    {miscompares, num_checks} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_RC, 0);
    rd(A_TC, 0);
    rd(A_RS, 0);
    rd(12'h0FC, 0);
    chk(last_err, 1);
    wr(`SFCS_OFS_IRQ_MASK, 3);
    // Every threshold code in both duplex modes, for both queues
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 4; c++) begin
        cap = m ? 2 : 4;
        th = m ? rxf[c] : rxh[c];
        wr(`SFCS_OFS_SETUP, 32'(m * 2 + 1));
        wr(A_RC, 32'h80);
        wr(A_TC, 32'h80);
        wr(A_RC, 32'(c));
        for (int k = 1; k < th; k++) u_chan.strobe(1'b0, 1'b1, 8'(16 + k));
        rd(A_IS, 0);
        u_chan.strobe(1'b0, 1'b1, 8'(16 + th));
        settle;
        chk(irq_ff, 1);
        rd(A_IS, 1);
        for (int k = th + 1; k <= cap + 1; k++) u_chan.strobe(1'b0, 1'b1, 8'(16 + k));
        rd(A_RS, 32'(128 + cap));
        wr(A_RC, 32'(64 + c));
        u_chan.strobe(1'b0, 1'b0, 8'h00);
        settle;
        chk(rx_data_ff, 8'h11);
        rd(A_IS, 32'(cap - 1 > th));
        exp_rx = exp_rx + 1 + ((cap - 1 > th) ? 1 : 0);
        wr(A_RC, 32'h80);
        rd(A_RS, 0);
        rd(A_RC, 0);
        th = m ? txf[c] : txh[c];
        wr(A_TC, 32'(c));
        for (int k = 1; k <= cap; k++) u_chan.strobe(1'b1, 1'b1, 8'(32 + k));
        for (int k = 1; k < cap - th; k++) u_chan.strobe(1'b1, 1'b0, 8'h00);
        rd(A_IS, 0);
        u_chan.strobe(1'b1, 1'b0, 8'h00);
        settle;
        chk(tx_data_ff, 8'(32 + cap - th));
        rd(A_IS, 2);
        wr(A_TC, 32'(64 + c));
        u_chan.strobe(1'b1, 1'b0, 8'h00);
        rd(A_IS, 32'(th > 0 ? 2 : 0));
        exp_tx = exp_tx + 1 + ((th > 0) ? 1 : 0);
        u_chan.strobe(1'b1, 1'b1, 8'h5A);
        wr(A_TC, 32'h80);
        rd(`SFCS_OFS_TX_STAT, 0);
        rd(A_TC, 0);
      end
    end
    // Masked event sets status but keeps the line low
    wr(`SFCS_OFS_IRQ_MASK, 0);
    wr(A_RC, 32'h80);
    wr(A_RC, 1);
    u_chan.strobe(1'b0, 1'b1, 8'h55);
    settle;
    chk(irq_ff, 0);
    rd(A_IS, 1);
    rd(A_IS, 0);
    // Every event gave exactly one pulse on its own line
    chk(rx_pulses, exp_rx + 1);
    chk(tx_pulses, exp_tx);
    rd(`SFCS_OFS_SETUP, 3);
    rd(`SFCS_OFS_IRQ_MASK, 0);
    // Queues still enabled: software writes the transmit configuration again and reads it back
    wr(A_TC, 32'h41);
    rd(A_TC, 32'h41);
    give_verdict;
  end
endmodule
`default_nettype wire
